// >>> dv/pfmo_power_stage.sv
// Model of the power stage: gate drivers on the pins, fault comparators on the fault lines.
// Assumes the bench commands trips; gate inputs carry pull-downs.
`timescale 1ns/100ps
module pfmo_power_stage (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic trip_a_in,
	input wire logic trip_b_in,
	input wire logic [5:0] pwm_in,
	input wire logic [5:0] oe_n_in,
	output logic fault_a_out,
	output logic fault_b_out,
	output logic [5:0] gate_out
);
	// A floating pin is pulled low, never left at its last level
	assign gate_out = pwm_in & ~oe_n_in;

	// Slow sensors switch mid-cycle, unrelated to the sampling edge; quiet from the first edge
	always @(posedge clk_in) begin
		fault_a_out <= #(slow_in ? 4.3 : 0.0) trip_a_in;
		fault_b_out <= #(slow_in ? 4.3 : 0.0) trip_b_in;
	end
endmodule : pfmo_power_stage

// >>> dv/pfmo_top_asserts.sv
// Port-level checker for the PWM fault and manual output block.
// Assumes the master always writes with full strobes; control bits are mirrored from the bus.
`timescale 1ns/100ps
module pfmo_top_asserts (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire pfmo_pkg::pfmo_axi_req_s axi_req_in,
	input wire pfmo_pkg::pfmo_axi_rsp_s axi_rsp_out,
	input wire logic fault_a_in,
	input wire logic fault_b_in,
	input wire logic [pfmo_pkg::NUM_PINS-1:0] pwm_out,
	input wire logic [pfmo_pkg::NUM_PINS-1:0] pwm_oe_n_out,
	input wire logic fault_irq_out
);
	import pfmo_pkg::*;
	logic [7:0] ra_q; // Last read address
	logic [7:0] wa_q; // Last write address
	logic [31:0] wd_q; // Last write data
	logic [1:0] ie_q; // Interrupt enables as written
	logic mod_q; // Module enable as written
	logic ovr_q; // Override as written
	logic [2:0] up_q; // Cycles since reset, saturating
	logic [2:0] cm_q; // Cycles since last write, saturating
	// Status read handshake, once the synchroniser has filled
	wire logic st_hs = axi_req_in.arvalid && axi_rsp_out.arready && axi_req_in.araddr == OFF_FAULT_STATUS && up_q == 3'h7;

	// Capture address and data at their own handshakes
	always_ff @(posedge clk_in) begin
		if (axi_req_in.arvalid && axi_rsp_out.arready) ra_q <= axi_req_in.araddr;
		if (axi_req_in.awvalid && axi_rsp_out.awready) wa_q <= axi_req_in.awaddr;
		if (axi_req_in.wvalid && axi_rsp_out.wready) wd_q <= axi_req_in.wdata;
	end

	// Commit on the rising answer, one edge after the design writes
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{ie_q, mod_q, ovr_q, up_q, cm_q} <= '0;
		end else begin
			up_q <= up_q + 3'(up_q != 3'h7);
			cm_q <= cm_q + 3'(cm_q != 3'h7);
			if ($rose(axi_rsp_out.bvalid)) begin
				cm_q <= '0;
				if (wa_q == OFF_CONTROL) {ie_q, mod_q} <= {wd_q[CT_IRQ_EN_B], wd_q[CT_IRQ_EN_A], wd_q[CT_MODULE_EN]};
				if (wa_q == OFF_OUTPUT_OVERRIDE) ovr_q <= wd_q[OO_ENABLE];
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_lvl_a;
		st_hs |=> axi_rsp_out.rdata[FS_LEVEL_A] == $past(fault_a_in, 3);
	endproperty
	a_lvl_a: assert property (p_lvl_a) else $error("level a differs from pin");
	property p_lvl_b;
		st_hs |=> axi_rsp_out.rdata[FS_LEVEL_B] == $past(fault_b_in, 3);
	endproperty
	a_lvl_b: assert property (p_lvl_b) else $error("level b differs from pin");
	property p_ack_zero;
		axi_rsp_out.rvalid && ra_q == OFF_FAULT_ACK |-> axi_rsp_out.rdata == 32'h0000_0000;
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("acknowledge read not zero");
	property p_stat_ro;
		axi_rsp_out.rvalid && ra_q == OFF_FAULT_STATUS |-> axi_rsp_out.rdata[31:4] == 28'h000_0000 && axi_rsp_out.rresp == RESP_OKAY;
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status read malformed");
	property p_irq_a;
		ie_q[0] && cm_q > 3'h2 && $rose(fault_a_in) |-> ##[1:4] fault_irq_out;
	endproperty
	a_irq_a: assert property (p_irq_a) else $error("fault a edge gave no request");
	property p_irq_b;
		ie_q[1] && cm_q > 3'h2 && $rose(fault_b_in) |-> ##[1:4] fault_irq_out;
	endproperty
	a_irq_b: assert property (p_irq_b) else $error("fault b edge gave no request");
	property p_irq_off;
		cm_q > 3'h2 && ie_q == 2'h0 |-> !fault_irq_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("request while both enables clear");
	property p_float;
		up_q == 3'h7 && cm_q > 3'h2 |-> pwm_oe_n_out == {NUM_PINS{~(mod_q | ovr_q)}};
	endproperty
	a_float: assert property (p_float) else $error("output enable wrong");
endmodule : pfmo_top_asserts

bind pfmo_top pfmo_top_asserts chk_u (
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.axi_req_in(axi_req_in),
	.axi_rsp_out(axi_rsp_out),
	.fault_a_in(fault_a_in),
	.fault_b_in(fault_b_in),
	.pwm_out(pwm_out),
	.pwm_oe_n_out(pwm_oe_n_out),
	.fault_irq_out(fault_irq_out)
);

// >>> dv/tb_pwm_fault_and_manual_output.sv
// Self-checking bench for the PWM fault and manual output block.
// Assumes the partner model in the same folder and the bound checker.
`timescale 1ns/100ps
module tb_pwm_fault_and_manual_output;
	import pfmo_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} pfmo_exp_s;
	logic clk_in = 1'b0; // Bus clock
	logic sys_rst_in; // Reset
	pfmo_axi_req_s req; // Master side
	pfmo_axi_rsp_s rsp; // Slave side
	logic fault_a; // Sensor lines
	logic fault_b;
	logic trip_a; // Trip commands
	logic trip_b;
	logic slow; // Late sensor answer
	logic irq;
	logic [5:0] pwm;
	logic [5:0] oe_n;
	logic [5:0] gate; // Level seen at the drivers
	logic [5:0] lv;
	logic [5:0] ex;
	int hw; // Measured high width of pin 0
	logic [31:0] ctl_t [3] = '{32'h0000_0061, 32'h0000_0063, 32'h0000_0069};
	int per_t [3] = '{10, 20, 20};
	pfmo_exp_s exp_q[$]; // Notes of expected answers
	int n_fail = 0;
	int comparisons = 0;

	always #5 clk_in = ~clk_in;

	pfmo_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .axi_req_in(req), .axi_rsp_out(rsp),
		.fault_a_in(fault_a), .fault_b_in(fault_b), .pwm_out(pwm), .pwm_oe_n_out(oe_n), .fault_irq_out(irq));
	pfmo_power_stage ps_u (.clk_in(clk_in), .slow_in(slow), .trip_a_in(trip_a), .trip_b_in(trip_b),
		.pwm_in(pwm), .oe_n_in(oe_n), .fault_a_out(fault_a), .fault_b_out(fault_b), .gate_out(gate));

	// Verdict and end of run
	task automatic end_sim();
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic timeout();
		n_fail++;
		end_sim();
	endtask : timeout
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask : check

	// One bus transfer; handshakes judged on values held over the edge
	task automatic xfer(input logic is_rd, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		logic aw;
		logic w;
		logic ar;
		logic done;
		exp_q.push_back('{d, m, r});
		if (is_rd) begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
		end else begin
			req.awaddr <= a;
			req.wdata <= d;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
		end
		done = 1'b0;
		for (int n = 0; n < 64 && !done; n++) begin
			@(negedge clk_in);
			aw = rsp.awready && req.awvalid;
			w = rsp.wready && req.wvalid;
			ar = rsp.arready && req.arvalid;
			done = rsp.bvalid || rsp.rvalid;
			@(posedge clk_in);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
			if (ar) req.arvalid <= 1'b0;
		end
		if (!done) timeout();
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b0, a, d, 32'h0000_0000, RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		xfer(1'b1, a, d, m, RESP_OKAY);
	endtask : rd
	task automatic trip(input logic a, input logic b, input logic s);
		trip_a <= a;
		trip_b <= b;
		slow <= s;
		repeat (6) @(posedge clk_in);
	endtask : trip
	// Negedges until pin 0 shows the level
	task automatic wait_pin(input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
			if (n > 300) timeout();
		end while (gate[0] !== v);
	endtask : wait_pin
	task automatic per(input int e);
		int hi;
		int lo;
		// Let the two-stage pin pipeline drop the old mode first
		repeat (2) @(posedge clk_in);
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
		check(32'(hi + lo), 32'(e));
	endtask : per

	// Compare each answer with the oldest note
	always @(negedge clk_in) begin
		pfmo_exp_s e;
		if (rsp.bvalid || rsp.rvalid) begin
			e = exp_q.pop_front();
			check({30'h0, rsp.bvalid ? rsp.bresp : rsp.rresp}, {30'h0, e.r});
			if (rsp.rvalid) check(rsp.rdata & e.m, e.d & e.m);
		end
	end

	// Main sequence
	initial begin
		req = '0;
		req.wstrb = 4'hf;
		req.bready = 1'b1;
		req.rready = 1'b1;
		sys_rst_in = 1'b1;
		{trip_a, trip_b, slow} = 3'h0;
		void'($urandom(32'h6b9d));
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		xfer(1'b1, 8'h1c, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
		wr(OFF_FAULT_STATUS, 32'h0000_000f);
		rd(OFF_FAULT_STATUS, 32'h0000_0000, 32'hffff_ffff);
		// Fault edges, enables off then on
		trip(1'b1, 1'b0, 1'b0);
		rd(OFF_FAULT_STATUS, 32'h0000_0003, 32'h0000_000f);
		check({31'h0, irq}, 32'h0000_0000);
		wr(OFF_CONTROL, 32'h0000_0060);
		repeat (3) @(posedge clk_in);
		check({31'h0, irq}, 32'h0000_0001);
		trip(1'b1, 1'b1, 1'b1);
		rd(OFF_FAULT_STATUS, 32'h0000_000f, 32'h0000_000f);
		trip(1'b0, 1'b0, 1'b0);
		rd(OFF_FAULT_STATUS, 32'h0000_0005, 32'h0000_000f);
		wr(OFF_FAULT_ACK, 32'h0000_0000);
		rd(OFF_FAULT_STATUS, 32'h0000_0005, 32'h0000_000f);
		wr(OFF_FAULT_ACK, 32'h0000_0001);
		rd(OFF_FAULT_STATUS, 32'h0000_0004, 32'h0000_000f);
		rd(OFF_FAULT_ACK, 32'h0000_0000, 32'hffff_ffff);
		wr(OFF_FAULT_ACK, 32'h0000_0002);
		rd(OFF_FAULT_STATUS, 32'h0000_0000, 32'h0000_000f);
		repeat (3) @(posedge clk_in);
		check({31'h0, irq}, 32'h0000_0000);
		// Manual levels, both pin modes, random patterns
		for (int i = 0; i < 8; i++) begin
			lv = 6'($urandom);
			ex = lv;
			for (int k = 0; k < 6; k += 2) if (i[0]) ex[k+1] = lv[k+1] ? ~ex[k] : 1'b0;
			wr(OFF_CONTROL, {29'h0, i[0], 2'h0});
			wr(OFF_OUTPUT_OVERRIDE, {25'h0, 1'b1, lv});
			repeat (4) @(posedge clk_in);
			check({26'h0, gate}, {26'h0, ex});
		end
		// Generator periods once override is dropped
		wr(OFF_MODULUS, 32'h0000_000a);
		wr(OFF_DUTY_BASE, 32'h0000_0005);
		wr(OFF_OUTPUT_OVERRIDE, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_CONTROL, ctl_t[i]);
			per(per_t[i]);
		end
		// Fault masks mapped pin until acknowledged
		wr(OFF_DISABLE_MAP, 32'h0000_0001);
		trip(1'b1, 1'b0, 1'b0);
		repeat (20) begin
			@(negedge clk_in);
			check({31'h0, gate[0]}, 32'h0000_0000);
		end
		wr(OFF_FAULT_ACK, 32'h0000_0001);
		per(20);
		wr(OFF_DEAD_TIME, 32'h0000_0005);
		wr(OFF_DEAD_TIME, 32'h0000_0009);
		rd(OFF_DEAD_TIME, 32'h0000_0005, 32'h0000_00ff);
		// Complementary pair: a 10-cycle request loses the 5-cycle dead time
		wr(OFF_MODULUS, 32'h0000_0014);
		wr(OFF_DUTY_BASE, 32'h0000_000a);
		wr(OFF_CONTROL, 32'h0000_0005);
		repeat (2) @(posedge clk_in);
		// Skip the first high, it may be cut by the mode switch
		for (int j = 0; j < 5; j++) wait_pin(j[0], hw);
		check(32'(hw), 32'h0000_0005);
		end_sim();
	end
endmodule : tb_pwm_fault_and_manual_output

// >>> src/pfmo_dead_time.sv
// Dead-time insertion for one complementary pin pair.
// Assumes the requests are on the bus clock; count is in bus cycles, unscaled.
`timescale 1ns/100ps
module pfmo_dead_time #(
	parameter int DW = pfmo_pkg::DT_W
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic comp_mode_in,
	input wire logic [pfmo_pkg::DT_W-1:0] dead_in,
	input wire logic top_req_in,
	input wire logic bot_req_in,
	output logic top_out,
	output logic bot_out
);
	import pfmo_pkg::*;

	// Counter lives in the packed state, so the width cannot differ
	if (DW != DT_W) begin : g_bad_width
		$error("pfmo_dead_time: DW must equal DT_W");
	end

	pfmo_dt_s s_q; // Registered state
	pfmo_dt_s s_d; // Next state
	logic changed; // Request changed this cycle

	// Next-state logic; in complementary mode both sides forced off while counting
	always_comb begin
		s_d = s_q;
		changed = (top_req_in != s_q.req_top) || (bot_req_in != s_q.req_bot);
		s_d.req_top = top_req_in;
		s_d.req_bot = bot_req_in;
		if (comp_mode_in && changed) begin
			s_d.cnt = dead_in;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		// Independent mode passes straight through
		if (!comp_mode_in || s_d.cnt == '0) begin
			s_d.top = top_req_in;
			s_d.bot = bot_req_in;
		end else begin
			s_d.top = 1'b0;
			s_d.bot = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_q <= DT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign top_out = s_q.top;
	assign bot_out = s_q.bot;

endmodule : pfmo_dead_time

// >>> src/pfmo_fault_chan.sv
// One fault input: two-flop synchroniser, rising-edge detect and sticky event flag.
// Assumes the pin is asynchronous and the clear pulse comes from the bus clock domain.
`timescale 1ns/100ps
module pfmo_fault_chan (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic fault_pin_in,
	input wire logic clear_in,
	output logic level_out,
	output logic flag_out
);
	import pfmo_pkg::*;

	pfmo_fault_s s_q; // Registered state
	pfmo_fault_s s_d; // Next state
	logic rise; // Synchronised rising edge

	// Next-state logic
	always_comb begin
		s_d = s_q;
		s_d.sync1 = fault_pin_in;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		rise = s_q.sync2 & ~s_q.prev;
		// Set beats clear so an edge in the ack cycle is kept
		if (rise) begin
			s_d.flag = 1'b1;
		end else if (clear_in) begin
			s_d.flag = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_q <= FAULT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_out = s_q.sync2;
	assign flag_out = s_q.flag;

endmodule : pfmo_fault_chan

// >>> src/pfmo_pkg.sv
// Package for the PWM fault and manual output block: register map, field positions,
// reset values, bus carriers and the packed state of each module.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package pfmo_pkg;

	// Bus widths
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h00;
	localparam logic [7:0] OFF_FAULT_ACK = 8'h04;
	localparam logic [7:0] OFF_OUTPUT_OVERRIDE = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_MODULUS = 8'h10;
	localparam logic [7:0] OFF_DEAD_TIME = 8'h14;
	localparam logic [7:0] OFF_DISABLE_MAP = 8'h18;
	localparam logic [7:0] OFF_DUTY_BASE = 8'h20;

	// Fault status fields
	localparam int FS_FLAG_A = 0;
	localparam int FS_LEVEL_A = 1;
	localparam int FS_FLAG_B = 2;
	localparam int FS_LEVEL_B = 3;
	// Fault acknowledge fields
	localparam int FA_CLEAR_A = 0;
	localparam int FA_CLEAR_B = 1;
	// Output override fields
	localparam int OO_LEVELS_LSB = 0;
	localparam int OO_ENABLE = 6;
	// Control fields
	localparam int CT_MODULE_EN = 0;
	localparam int CT_CENTER = 1;
	localparam int CT_COMP = 2;
	localparam int CT_PRESC_LSB = 3;
	localparam int CT_IRQ_EN_A = 5;
	localparam int CT_IRQ_EN_B = 6;

	// Sizes and counts
	localparam int NUM_PINS = 6;
	localparam int NUM_PAIRS = 3;
	localparam int MOD_W = 12;
	localparam int DT_W = 8;
	localparam int PRE_W = 3;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// AXI4-Lite request from the master
	typedef struct packed {
		logic [AXI_AW-1:0] awaddr;
		logic awvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [AXI_AW-1:0] araddr;
		logic arvalid;
		logic rready;
	} pfmo_axi_req_s;

	// AXI4-Lite answer of the slave
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
	} pfmo_axi_rsp_s;

	// Fault channel state
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic flag;
	} pfmo_fault_s;

	// Dead-time pair state
	typedef struct packed {
		logic req_top;
		logic req_bot;
		logic [DT_W-1:0] cnt;
		logic top;
		logic bot;
	} pfmo_dt_s;

	// Top-level state
	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_held;
		logic [AXI_AW-1:0] awaddr;
		logic w_held;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [15:0] rdata;
		logic [1:0] rresp;
		logic ovr_en;
		logic [NUM_PINS-1:0] man_lv;
		logic mod_en;
		logic center;
		logic comp;
		logic [1:0] presc;
		logic irq_en_a;
		logic irq_en_b;
		logic [MOD_W-1:0] modulus;
		logic [NUM_PINS-1:0][MOD_W-1:0] duty;
		logic [DT_W-1:0] dead;
		logic dead_wr;
		logic [7:0] dmap;
		logic dmap_wr;
		logic [PRE_W-1:0] pre_cnt;
		logic [MOD_W:0] phase;
		logic [NUM_PINS-1:0] pwm;
		logic [NUM_PINS-1:0] oe_n;
		logic irq;
	} pfmo_top_s;

	// Reset values
	localparam pfmo_fault_s FAULT_RST = '0;
	localparam pfmo_dt_s DT_RST = '0;
	// Pins float while held in reset: the module is disabled then
	localparam pfmo_top_s TOP_RST = '{oe_n: '1, default: '0};

endpackage : pfmo_pkg

// >>> src/pfmo_top.sv
// PWM fault status, fault acknowledge, manual override and a small PWM generator,
// reached over AXI4-Lite. Assumes one 100 MHz clock and a synchronous high reset.
`timescale 1ns/100ps
module pfmo_top (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire pfmo_pkg::pfmo_axi_req_s axi_req_in,
	output pfmo_pkg::pfmo_axi_rsp_s axi_rsp_out,
	input wire logic fault_a_in,
	input wire logic fault_b_in,
	output logic [pfmo_pkg::NUM_PINS-1:0] pwm_out,
	output logic [pfmo_pkg::NUM_PINS-1:0] pwm_oe_n_out,
	output logic fault_irq_out
);
	import pfmo_pkg::*;

	pfmo_top_s s_q; // Registered state
	pfmo_top_s s_d; // Next state

	logic level_a; // Synchronised fault A level
	logic level_b; // Synchronised fault B level
	logic fault_event_flag_a; // Sticky fault A flag
	logic fault_event_flag_b; // Sticky fault B flag
	logic fault_clear_a; // One-cycle clear pulse A
	logic fault_clear_b; // One-cycle clear pulse B
	logic do_write; // Both halves of a write held
	logic [NUM_PINS-1:0] gen_lv; // Generator pin levels
	logic [NUM_PINS-1:0] dt_req; // Dead-time stage inputs
	logic [NUM_PINS-1:0] dt_out; // Dead-time stage outputs
	logic [MOD_W:0] limit; // Last phase of a period
	logic [MOD_W:0] cnt_val; // Up/down counter value
	logic tick; // Prescaled counter tick
	logic [PRE_W-1:0] pre_top; // Prescaler terminal count
	logic [15:0] rd_val; // Read mux result
	logic rd_ok; // Read address mapped
	logic wr_ok; // Write address mapped
	logic any_fault; // Either fault flag set

	// Fault channels; flags cleared by the acknowledge pulses
	pfmo_fault_chan u_fault_a (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.fault_pin_in(fault_a_in),
		.clear_in(fault_clear_a),
		.level_out(level_a),
		.flag_out(fault_event_flag_a)
	);
	pfmo_fault_chan u_fault_b (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.fault_pin_in(fault_b_in),
		.clear_in(fault_clear_b),
		.level_out(level_b),
		.flag_out(fault_event_flag_b)
	);

	// Source select per pair, then dead-time; no settle delay on switch back
	for (genvar k = 0; k < NUM_PAIRS; k++) begin : g_pair
		always_comb begin
			if (s_q.ovr_en) begin
				dt_req[2*k] = s_q.man_lv[2*k];
				if (s_q.comp) begin
					dt_req[2*k+1] = s_q.man_lv[2*k+1] & ~s_q.man_lv[2*k];
				end else begin
					dt_req[2*k+1] = s_q.man_lv[2*k+1];
				end
			end else begin
				dt_req[2*k] = gen_lv[2*k];
				if (s_q.comp) begin
					dt_req[2*k+1] = ~gen_lv[2*k];
				end else begin
					dt_req[2*k+1] = gen_lv[2*k+1];
				end
			end
		end
		pfmo_dead_time #(
			.DW(DT_W)
		) u_dead (
			.clk_in(clk_in),
			.sys_rst_in(sys_rst_in),
			.comp_mode_in(s_q.comp),
			.dead_in(s_q.dead),
			.top_req_in(dt_req[2*k]),
			.bot_req_in(dt_req[2*k+1]),
			.top_out(dt_out[2*k]),
			.bot_out(dt_out[2*k+1])
		);
	end

	// Generator compare, one duty per pin
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_cmp
		assign gen_lv[p] = s_q.mod_en && (cnt_val < {1'b0, s_q.duty[p]});
	end

	// Counter shape and prescaler
	always_comb begin
		pre_top = PRE_W'((1 << s_q.presc) - 1);
		tick = (s_q.pre_cnt == pre_top);
		if (s_q.center) begin
			limit = {s_q.modulus, 1'b0} - 1'b1;
			if (s_q.phase < {1'b0, s_q.modulus}) begin
				cnt_val = s_q.phase;
			end else begin
				cnt_val = {s_q.modulus, 1'b0} - 1'b1 - s_q.phase;
			end
		end else begin
			limit = {1'b0, s_q.modulus} - 1'b1;
			cnt_val = s_q.phase;
		end
	end

	// Bus write decode and clear pulses
	always_comb begin
		do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
		fault_clear_a = 1'b0;
		fault_clear_b = 1'b0;
		// Clear bits are single pulses; nothing is stored, reads give zero
		if (do_write && s_q.awaddr == OFF_FAULT_ACK && s_q.wstrb[0]) begin
			fault_clear_a = s_q.wdata[FA_CLEAR_A];
			fault_clear_b = s_q.wdata[FA_CLEAR_B];
		end
		wr_ok = 1'b0;
		case (s_q.awaddr)
			OFF_FAULT_STATUS: wr_ok = 1'b1;
			OFF_FAULT_ACK: wr_ok = 1'b1;
			OFF_OUTPUT_OVERRIDE: wr_ok = 1'b1;
			OFF_CONTROL: wr_ok = 1'b1;
			OFF_MODULUS: wr_ok = 1'b1;
			OFF_DEAD_TIME: wr_ok = 1'b1;
			OFF_DISABLE_MAP: wr_ok = 1'b1;
			default: wr_ok = (s_q.awaddr >= OFF_DUTY_BASE) &&
				(s_q.awaddr < OFF_DUTY_BASE + 8'(4 * NUM_PINS)) && (s_q.awaddr[1:0] == 2'h0);
		endcase
	end

	// Bus read mux; unmapped addresses answer zero with an error
	always_comb begin
		rd_val = 16'h0000;
		rd_ok = 1'b1;
		case (axi_req_in.araddr)
			OFF_FAULT_STATUS: begin
				rd_val[FS_FLAG_A] = fault_event_flag_a;
				rd_val[FS_LEVEL_A] = level_a;
				rd_val[FS_FLAG_B] = fault_event_flag_b;
				rd_val[FS_LEVEL_B] = level_b;
			end
			OFF_FAULT_ACK: rd_val = 16'h0000;
			OFF_OUTPUT_OVERRIDE: begin
				rd_val[OO_LEVELS_LSB +: NUM_PINS] = s_q.man_lv;
				rd_val[OO_ENABLE] = s_q.ovr_en;
			end
			OFF_CONTROL: begin
				rd_val[CT_MODULE_EN] = s_q.mod_en;
				rd_val[CT_CENTER] = s_q.center;
				rd_val[CT_COMP] = s_q.comp;
				rd_val[CT_PRESC_LSB +: 2] = s_q.presc;
				rd_val[CT_IRQ_EN_A] = s_q.irq_en_a;
				rd_val[CT_IRQ_EN_B] = s_q.irq_en_b;
			end
			OFF_MODULUS: rd_val[MOD_W-1:0] = s_q.modulus;
			OFF_DEAD_TIME: rd_val[DT_W-1:0] = s_q.dead;
			OFF_DISABLE_MAP: rd_val[7:0] = s_q.dmap;
			default: begin
				rd_ok = 1'b0;
				// Duty registers, one word per pin
				for (int i = 0; i < NUM_PINS; i++) begin
					if (axi_req_in.araddr == OFF_DUTY_BASE + 8'(4 * i)) begin
						rd_val[MOD_W-1:0] = s_q.duty[i];
						rd_ok = 1'b1;
					end
				end
			end
		endcase
	end

	// Next-state logic
	always_comb begin
		s_d = s_q;
		any_fault = fault_event_flag_a | fault_event_flag_b;

		// Write address and data accepted in either order
		if (axi_req_in.awvalid && s_q.awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = axi_req_in.awaddr;
		end
		if (axi_req_in.wvalid && s_q.wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = axi_req_in.wdata[15:0];
			s_d.wstrb = axi_req_in.wstrb[1:0];
		end
		if (s_q.bvalid && axi_req_in.bready) begin
			s_d.bvalid = 1'b0;
		end
		if (do_write) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
			// Fault status is absent here, so writes to it change nothing
			if (s_q.wstrb[0]) begin
				case (s_q.awaddr)
					OFF_OUTPUT_OVERRIDE: begin
						s_d.man_lv = s_q.wdata[OO_LEVELS_LSB +: NUM_PINS];
						s_d.ovr_en = s_q.wdata[OO_ENABLE];
					end
					OFF_CONTROL: begin
						s_d.mod_en = s_q.wdata[CT_MODULE_EN];
						s_d.center = s_q.wdata[CT_CENTER];
						s_d.comp = s_q.wdata[CT_COMP];
						s_d.presc = s_q.wdata[CT_PRESC_LSB +: 2];
						s_d.irq_en_a = s_q.wdata[CT_IRQ_EN_A];
						s_d.irq_en_b = s_q.wdata[CT_IRQ_EN_B];
					end
					OFF_DEAD_TIME: begin
						// Locked after first write until reset
						if (!s_q.dead_wr) begin
							s_d.dead = s_q.wdata[DT_W-1:0];
							s_d.dead_wr = 1'b1;
						end
					end
					OFF_DISABLE_MAP: begin
						if (!s_q.dmap_wr) begin
							s_d.dmap = s_q.wdata[7:0];
							s_d.dmap_wr = 1'b1;
						end
					end
					default: begin
						// Modulus and duty are written below; other offsets hold nothing in the low lane
					end
				endcase
			end
			// Twelve-bit counts span two byte lanes
			if (s_q.awaddr == OFF_MODULUS) begin
				if (s_q.wstrb[0]) begin
					s_d.modulus[7:0] = s_q.wdata[7:0];
				end
				if (s_q.wstrb[1]) begin
					s_d.modulus[MOD_W-1:8] = s_q.wdata[MOD_W-1:8];
				end
			end
			for (int i = 0; i < NUM_PINS; i++) begin
				if (s_q.awaddr == OFF_DUTY_BASE + 8'(4 * i)) begin
					if (s_q.wstrb[0]) begin
						s_d.duty[i][7:0] = s_q.wdata[7:0];
					end
					if (s_q.wstrb[1]) begin
						s_d.duty[i][MOD_W-1:8] = s_q.wdata[MOD_W-1:8];
					end
				end
			end
		end
		// Ready only while the slot is free and no answer is pending
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready = !s_d.w_held && !s_d.bvalid;

		// Read channel: one read in flight
		if (s_q.rvalid && axi_req_in.rready) begin
			s_d.rvalid = 1'b0;
		end
		if (axi_req_in.arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val;
			s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		s_d.arready = !s_d.rvalid;

		// Counter keeps running under override; only a clear enable or a zero modulus stops it
		if (!s_q.mod_en || s_q.modulus == '0) begin
			s_d.pre_cnt = '0;
			s_d.phase = '0;
		end else begin
			s_d.pre_cnt = tick ? '0 : s_q.pre_cnt + 1'b1;
			if (tick) begin
				s_d.phase = (s_q.phase >= limit) ? '0 : s_q.phase + 1'b1;
			end
		end

		// Output stage: fault mask forces mapped pins inactive
		for (int i = 0; i < NUM_PINS; i++) begin
			s_d.pwm[i] = dt_out[i] & ~(any_fault & s_q.dmap[i]);
			s_d.oe_n[i] = !(s_q.mod_en || s_q.ovr_en);
		end
		s_d.irq = (fault_event_flag_a & s_q.irq_en_a) | (fault_event_flag_b & s_q.irq_en_b);
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_q <= TOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		axi_rsp_out.awready = s_q.awready;
		axi_rsp_out.wready = s_q.wready;
		axi_rsp_out.bvalid = s_q.bvalid;
		axi_rsp_out.bresp = s_q.bresp;
		axi_rsp_out.arready = s_q.arready;
		axi_rsp_out.rvalid = s_q.rvalid;
		axi_rsp_out.rdata = {16'h0000, s_q.rdata};
		axi_rsp_out.rresp = s_q.rresp;
	end
	assign pwm_out = s_q.pwm;
	assign pwm_oe_n_out = s_q.oe_n;
	assign fault_irq_out = s_q.irq;

endmodule : pfmo_top
